// ---- hw/fsps_seq.sv ----
// Purpose: Flash self-program sequencer: erase, load, write, lock, fuse read
// Assumes: CPU strobes spmExec/lpmExec for one cycle per instruction
// Notes:   rst is power-on; sysRst is the CPU system reset and spares a running op
`default_nettype none
module fsps_seq
  import fsps_pkg::*;
#(
  parameter int PROG_TICKS = PROG_TICKS_DFLT,
  parameter int TICK_W     = 16
)(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        sysRst,
  input  wire logic        ctrlWrEn,
  input  wire logic [7:0]  ctrlWrData,
  output logic      [7:0]  ctrlRdData,
  input  wire logic        spmExec,
  input  wire logic        lpmExec,
  input  wire logic [15:0] zPtr,
  input  wire logic [7:0]  dataLow,
  input  wire logic [7:0]  dataHigh,
  input  wire logic        globalIntEn,
  input  wire logic        eepromWriteBusy,
  input  wire logic        rcOscClk,
  input  wire logic [5:0]  lockProg,
  input  wire logic [7:0]  fuseLowProg,
  input  wire logic [7:0]  fuseHighProg,
  input  wire logic [2:0]  fuseExtProg,
  input  wire logic [5:0]  flashWordIdx,
  output logic      [15:0] flashWordData,
  output logic             flashOpStart,
  output logic      [1:0]  flashOpKind,
  output logic      [7:0]  flashPageAddr,
  output logic             flashOpActive,
  output logic      [5:0]  lockProgMask,
  output logic             readRwwBlocked,
  output logic             cpuHalt,
  output logic             spmReadyIrq,
  output logic             readOverValid,
  output logic      [7:0]  readOverData
);
  // ************************************************************
  // State
  // ************************************************************
  logic              intEn_ff;
  logic              rwwBusy_ff;
  logic [4:0]        cmd_ff;
  logic [2:0]        armCnt_ff;
  logic              eePrev_ff;
  fsps_state_t       state_ff;
  fsps_op_t          kind_ff;
  logic [PAGE_W-1:0] page_ff;
  logic [5:0]        mask_ff;
  logic              start_ff;
  logic [TICK_W-1:0] progCnt_ff;
  logic              rdValid_ff;
  logic [7:0]        rdData_ff;
  logic              nxt_intEn;
  logic              nxt_rwwBusy;
  logic [4:0]        nxt_cmd;
  logic [2:0]        nxt_armCnt;
  fsps_state_t       nxt_state;
  fsps_op_t          nxt_kind;
  logic [PAGE_W-1:0] nxt_page;
  logic [5:0]        nxt_mask;
  logic              nxt_start;
  logic [TICK_W-1:0] nxt_progCnt;
  logic              nxt_rdValid;
  logic [7:0]        nxt_rdData;
  logic              rcTick;
  logic              armed;
  logic              spmGo;
  logic              lpmGo;
  logic              cmdErase;
  logic              cmdWrite;
  logic              cmdLock;
  logic              cmdLoad;
  logic              cmdReen;
  logic              csrWr;
  logic              bufWr;
  logic              bufClr;
  logic              eeRise;
  logic              rwwOp;

  // ************************************************************
  // RC oscillator tick
  // ************************************************************
  fsps_sync u_rcSync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (rcOscClk),
    .level   (),
    .rise    (rcTick)
  );

  // ************************************************************
  // Command decode
  // ************************************************************
  // EEPROM busy gates
  assign armed    = cmd_ff[CSR_BIT_EN] && armCnt_ff != 3'h0 && !eepromWriteBusy && state_ff == ST_IDLE;
  assign spmGo    = spmExec && armed && !sysRst;
  assign lpmGo    = lpmExec && armed && !sysRst && cmd_ff == CMD_LOCK && armCnt_ff > (SPM_WINDOW - LPM_WINDOW);
  assign cmdErase = spmGo && cmd_ff == CMD_ERASE;
  assign cmdWrite = spmGo && cmd_ff == CMD_WRITE;
  assign cmdLock  = spmGo && cmd_ff == CMD_LOCK;
  assign cmdLoad  = spmGo && cmd_ff == CMD_LOAD;
  assign cmdReen  = spmGo && cmd_ff == CMD_REEN;
  // Command bits frozen while an op runs so the enable bit tracks it
  assign csrWr    = ctrlWrEn && !eepromWriteBusy && state_ff == ST_IDLE && !sysRst;
  assign eeRise   = eepromWriteBusy && !eePrev_ff;
  assign rwwOp    = state_ff != ST_IDLE && kind_ff != OP_LOCK;

  // ************************************************************
  // Page buffer
  // ************************************************************
  // Word write at word field
  assign bufWr  = cmdLoad;
  assign bufClr = cmdReen || sysRst || eeRise || (state_ff == ST_DONE && kind_ff == OP_WRITE);

  fsps_page_buf u_buf (
    .mclk   (mclk),
    .rst    (rst),
    .clr    (bufClr),
    .wrEn   (bufWr),
    .wrIdx  (zPtr[WORD_LSB +: WORD_W]),
    .wrData ({dataHigh, dataLow}),
    .rdIdx  (flashWordIdx),
    .rdData (flashWordData)
  );

  // ************************************************************
  // Control/status register
  // ************************************************************
  always_comb begin
    nxt_intEn   = intEn_ff;
    nxt_rwwBusy = rwwBusy_ff;
    nxt_cmd     = cmd_ff;
    nxt_armCnt  = armCnt_ff;
    if (armCnt_ff != 3'h0) begin
      nxt_armCnt = armCnt_ff - 3'h1;
    end
    if (armCnt_ff == 3'h1 && state_ff == ST_IDLE) begin
      nxt_cmd = CMD_RESET;
    end
    if (spmGo || lpmGo) begin
      nxt_armCnt = 3'h0;
      if (!(cmdErase || cmdWrite || cmdLock)) begin
        nxt_cmd = CMD_RESET;
      end
    end
    if (cmdErase || cmdWrite) begin
      nxt_rwwBusy = 1'b1;
    end
    if (cmdReen) begin
      nxt_rwwBusy = 1'b0;
    end
    if (state_ff == ST_DONE) begin
      nxt_cmd = CMD_RESET;
    end
    if (ctrlWrEn) begin
      nxt_intEn = ctrlWrData[CSR_BIT_IE];
    end
    if (csrWr) begin
      nxt_cmd    = ctrlWrData[CSR_BIT_REEN:CSR_BIT_EN];
      nxt_armCnt = ctrlWrData[CSR_BIT_EN] ? SPM_WINDOW : 3'h0;
    end
    if (sysRst) begin
      nxt_intEn   = 1'b0;
      nxt_cmd     = CMD_RESET;
      nxt_armCnt  = 3'h0;
      nxt_rwwBusy = rwwBusy_ff && rwwOp;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intEn_ff   <= 1'b0;
      rwwBusy_ff <= 1'b0;
      cmd_ff     <= CMD_RESET;
      armCnt_ff  <= 3'h0;
      eePrev_ff  <= 1'b0;
    end else begin
      intEn_ff   <= nxt_intEn;
      rwwBusy_ff <= nxt_rwwBusy;
      cmd_ff     <= nxt_cmd;
      armCnt_ff  <= nxt_armCnt;
      eePrev_ff  <= eepromWriteBusy;
    end
  end

  // ************************************************************
  // Operation sequencer and fuse/lock reads
  // ************************************************************
  always_comb begin
    nxt_state   = state_ff;
    nxt_kind    = kind_ff;
    nxt_page    = page_ff;
    nxt_mask    = mask_ff;
    nxt_start   = 1'b0;
    nxt_progCnt = progCnt_ff;
    nxt_rdValid = 1'b0;
    nxt_rdData  = rdData_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cmdErase || cmdWrite || cmdLock) begin
          nxt_state   = ST_PROG;
          nxt_start   = 1'b1;
          nxt_progCnt = '0;
          nxt_kind    = cmdErase ? OP_ERASE : (cmdWrite ? OP_WRITE : OP_LOCK);
        end
        if (cmdErase || cmdWrite) begin
          nxt_page = zPtr[PAGE_LSB +: PAGE_W];
        end
        if (cmdLock) begin
          nxt_mask = ~dataLow[5:0];
        end
      end
      ST_PROG: begin
        if (rcTick) begin
          if (progCnt_ff == TICK_W'(PROG_TICKS - 1)) begin
            nxt_state = ST_DONE;
          end else begin
            nxt_progCnt = progCnt_ff + 1'b1;
          end
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (lpmGo) begin
      nxt_rdValid = 1'b1;
      if (zPtr == ZPTR_LOCK) begin
        nxt_rdData = {LOCK_RD_TOP, ~lockProg};
      end else if (zPtr == ZPTR_FUSE_LOW) begin
        nxt_rdData = ~fuseLowProg;
      end else if (zPtr == ZPTR_FUSE_HIGH) begin
        nxt_rdData = ~fuseHighProg;
      end else if (zPtr == ZPTR_FUSE_EXT) begin
        nxt_rdData = {EXT_RD_TOP, ~fuseExtProg};
      end else begin
        nxt_rdValid = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      kind_ff    <= OP_ERASE;
      page_ff    <= '0;
      mask_ff    <= 6'h00;
      start_ff   <= 1'b0;
      progCnt_ff <= '0;
      rdValid_ff <= 1'b0;
      rdData_ff  <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      kind_ff    <= nxt_kind;
      page_ff    <= nxt_page;
      mask_ff    <= nxt_mask;
      start_ff   <= nxt_start;
      progCnt_ff <= nxt_progCnt;
      rdValid_ff <= nxt_rdValid;
      rdData_ff  <= nxt_rdData;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign ctrlRdData     = {intEn_ff, rwwBusy_ff, 1'b0, cmd_ff};
  assign flashOpStart   = start_ff;
  assign flashOpKind    = kind_ff;
  assign flashPageAddr  = page_ff;
  assign flashOpActive  = state_ff == ST_PROG;
  assign lockProgMask   = mask_ff;
  assign readRwwBlocked = rwwOp;
  assign cpuHalt        = rwwOp && page_ff >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
  assign spmReadyIrq    = intEn_ff && globalIntEn && !cmd_ff[CSR_BIT_EN];
  assign readOverValid  = rdValid_ff;
  assign readOverData   = rdData_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence armWrite;
    ctrlWrEn && ctrlWrData[CSR_BIT_EN] && !eepromWriteBusy && state_ff == ST_IDLE && !sysRst;
  endsequence
  sequence quietFour;
    (!spmExec && !lpmExec && !ctrlWrEn && !sysRst)[*4];
  endsequence

  a_window_expire: assert property (armWrite ##1 quietFour |=> !ctrlRdData[CSR_BIT_EN])
    else $error("enable bit survived an unused window");
  a_refuse_eeprom: assert property (eepromWriteBusy && spmExec |=> !flashOpStart)
    else $error("op started during EEPROM write");
  a_unarmed_store: assert property (spmExec && !armed |-> !bufWr ##1 !flashOpStart)
    else $error("unarmed store had an effect");
  a_fuse_invert: assert property (lpmGo && zPtr == ZPTR_FUSE_LOW |=>
    readOverValid && readOverData == ~$past(fuseLowProg))
    else $error("fuse low byte not returned inverted");
  a_irq_ready: assert property ($fell(ctrlRdData[CSR_BIT_EN]) && intEn_ff && globalIntEn |-> spmReadyIrq)
    else $error("ready interrupt missing");
  a_halt_no_read_while_write_section: assert property (cpuHalt |-> readRwwBlocked && flashPageAddr >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
    else $error("halt outside no-read section op");
  a_busy_flag: assert property (flashOpStart && flashOpKind != OP_LOCK |->
    ctrlRdData[CSR_BIT_RWWB] && readRwwBlocked)
    else $error("busy flag or block missing");
  a_lock_readable: assert property (flashOpActive && flashOpKind == OP_LOCK |-> !readRwwBlocked && !cpuHalt)
    else $error("lock programming blocked reads");
  a_prog_time: assert property ($fell(flashOpActive) |-> $past(progCnt_ff) == TICK_W'(PROG_TICKS - 1))
    else $error("op ended at wrong tick count");
endmodule
`default_nettype wire

// ---- hw/fsps_pkg.sv ----
// Purpose: Shared constants and types of the flash self-program sequencer
// Assumes: One clock (mclk), control register bit layout fixed
// Notes:   Lock and fuse inputs are raw cell states, 1 means programmed
`default_nettype none
package fsps_pkg;
  // ************************************************************
  // Control/status register layout
  // ************************************************************
  localparam int          CSR_BIT_IE   = 7;
  localparam int          CSR_BIT_RWWB = 6;
  localparam int          CSR_BIT_REEN = 4;
  localparam int          CSR_BIT_LOCK = 3;
  localparam int          CSR_BIT_PGWR = 2;
  localparam int          CSR_BIT_PGER = 1;
  localparam int          CSR_BIT_EN   = 0;
  localparam logic [4:0]  CMD_RESET    = 5'h00;
  localparam logic [4:0]  CMD_LOAD     = 5'h01;
  localparam logic [4:0]  CMD_ERASE    = 5'h03;
  localparam logic [4:0]  CMD_WRITE    = 5'h05;
  localparam logic [4:0]  CMD_LOCK     = 5'h09;
  localparam logic [4:0]  CMD_REEN     = 5'h11;
  // ************************************************************
  // Timed sequence windows, in mclk cycles
  // ************************************************************
  localparam logic [2:0]  SPM_WINDOW   = 3'h4;
  localparam logic [2:0]  LPM_WINDOW   = 3'h3;
  // ************************************************************
  // Pointer fields and read selectors
  // ************************************************************
  localparam int          PAGE_LSB     = 7;
  localparam int          PAGE_W       = 8;
  localparam int          WORD_LSB     = 1;
  localparam int          WORD_W       = 6;
  localparam logic [7:0]  NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 8'he0;
  localparam logic [15:0] ZPTR_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] ZPTR_LOCK      = 16'h0001;
  localparam logic [15:0] ZPTR_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] ZPTR_FUSE_HIGH = 16'h0003;
  localparam logic [1:0]  LOCK_RD_TOP    = 2'h3;
  localparam logic [4:0]  EXT_RD_TOP     = 5'h1f;
  // ************************************************************
  // Page buffer
  // ************************************************************
  localparam int          BUF_WORDS    = 64;
  localparam logic [15:0] BUF_ERASED   = 16'hffff;
  // ************************************************************
  // Programming time, counted on the RC oscillator
  // ************************************************************
  localparam int          PROG_MIN_US  = 3700;
  localparam int          PROG_MAX_US  = 4500;
  localparam int          PROG_TGT_US  = (PROG_MIN_US + PROG_MAX_US) / 2;
  localparam int          RC_KHZ       = 8000;
  localparam int          PROG_TICKS_DFLT = PROG_TGT_US * RC_KHZ / 1000;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_DONE = 3'b100
  } fsps_state_t;
  typedef enum logic [1:0] {
    OP_ERASE = 2'h0,
    OP_WRITE = 2'h1,
    OP_LOCK  = 2'h2
  } fsps_op_t;
endpackage
`default_nettype wire

// ---- hw/fsps_sync.sv ----
// Purpose: Three-stage synchroniser with agreement filter and rise pulse
// Assumes: asyncIn is slower than mclk / 4
// Notes:   Stage one feeds stage two only
`default_nettype none
module fsps_sync
  import fsps_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      level,
  output logic      rise
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic stable_ff;
  logic rise_ff;
  logic nxt_stable;
  logic nxt_rise;

  // ************************************************************
  // Accept a change once stages two and three agree
  // ************************************************************
  always_comb begin
    nxt_stable = (s2_ff == s3_ff) ? s2_ff : stable_ff;
    nxt_rise   = nxt_stable & ~stable_ff;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_ff     <= 1'b0;
      s2_ff     <= 1'b0;
      s3_ff     <= 1'b0;
      stable_ff <= 1'b0;
      rise_ff   <= 1'b0;
    end else begin
      s1_ff     <= asyncIn;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      stable_ff <= nxt_stable;
      rise_ff   <= nxt_rise;
    end
  end

  assign level = stable_ff;
  assign rise  = rise_ff;
endmodule
`default_nettype wire

// ---- hw/fsps_page_buf.sv ----
// Purpose: Temporary page buffer, one word per entry, flip-flop storage
// Assumes: Clear and write never needed in the same cycle; clear wins
// Notes:   Cleared entries read as erased flash
`default_nettype none
module fsps_page_buf
  import fsps_pkg::*;
#(
  parameter int WORDS = BUF_WORDS,
  parameter int IDX_W = WORD_W
)(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clr,
  input  wire logic             wrEn,
  input  wire logic [IDX_W-1:0] wrIdx,
  input  wire logic [15:0]      wrData,
  input  wire logic [IDX_W-1:0] rdIdx,
  output logic      [15:0]      rdData
);
  logic [15:0] mem_ff [WORDS];
  logic [15:0] nxt_mem [WORDS];

  // ************************************************************
  // Per-entry update
  // ************************************************************
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_comb begin
      nxt_mem[i] = mem_ff[i];
      if (clr) begin
        nxt_mem[i] = BUF_ERASED;
      end else if (wrEn && wrIdx == IDX_W'(i)) begin
        nxt_mem[i] = wrData;
      end
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        mem_ff[i] <= BUF_ERASED;
      end else begin
        mem_ff[i] <= nxt_mem[i];
      end
    end
  end

  assign rdData = mem_ff[rdIdx];
endmodule
`default_nettype wire

// ---- verification/fsps_cpu_model.sv ----
// Purpose: CPU model issuing the boot loader timed sequences
// Assumes: Tasks are called 1 ns after a rising mclk edge
// Notes:   Released lines show the inverse of their last value
`default_nettype none
module fsps_cpu_model
  import fsps_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        eepromWriteBusy,
  output var  logic        ctrlWrEn,
  output var  logic [7:0]  ctrlWrData,
  output var  logic        spmExec,
  output var  logic        lpmExec,
  output var  logic [15:0] zPtr,
  output var  logic [7:0]  dataLow,
  output var  logic [7:0]  dataHigh,
  output var  logic        globalIntEn
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Instruction tasks
  // ************************************************************
  initial begin
    {ctrlWrEn, spmExec, lpmExec, globalIntEn} = 4'h0;
    {ctrlWrData, zPtr, dataLow, dataHigh} = 40'h0;
  end
  task automatic ctrlWr(input logic [7:0] d, input bit ee = 1'b1);
    @(posedge mclk) #1;
    while (ee && eepromWriteBusy) @(posedge mclk) #1;
    ctrlWrEn = 1'h1;
    ctrlWrData = d;
    @(posedge mclk) #1;
    ctrlWrEn = 1'h0;
    ctrlWrData = ~d;
  endtask
  task automatic spm(input logic [15:0] z, input logic [15:0] d);
    spmExec = 1'h1;
    zPtr = z;
    {dataHigh, dataLow} = d;
    @(posedge mclk) #1;
    spmExec = 1'h0;
    zPtr = ~z;
    {dataHigh, dataLow} = ~d;
  endtask
  task automatic lpm(input logic [15:0] z);
    lpmExec = 1'h1;
    zPtr = z;
    @(posedge mclk) #1;
    lpmExec = 1'h0;
    zPtr = ~z;
  endtask
endmodule
`default_nettype wire

// ---- verification/fsps_seq_tb_top.sv ----
// Purpose: Self-checking bench of the flash self-program sequencer
// Assumes: PROG_TICKS cut to 4 RC ticks
// Notes:   Long waits are bounded; RC runs free at 8 MHz
`default_nettype none
module fsps_seq_tb_top
  import fsps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic        mclk = 0, rst = 1, sysRst = 0, eepromWriteBusy = 0, rcOscClk = 0;
  logic [5:0]  lockProg = 6'h05, flashWordIdx = 6'h00, lockProgMask;
  logic [7:0]  fuseLowProg = 8'h81, fuseHighProg = 8'h3c, pg;
  logic [2:0]  fuseExtProg = 3'h2;
  logic [7:0]  ctrlWrData, ctrlRdData, dataLow, dataHigh, flashPageAddr, readOverData;
  logic [15:0] zPtr, flashWordData;
  logic [1:0]  flashOpKind;
  logic        ctrlWrEn, spmExec, lpmExec, globalIntEn, flashOpStart, flashOpActive;
  logic        readRwwBlocked, cpuHalt, spmReadyIrq, readOverValid;
  logic [7:0]  rdExp [4];
  int          err_count = 0, n_compared = 0, cyc = 0;
  always #2 mclk = ~mclk;
  always #62.5 rcOscClk = ~rcOscClk;
  fsps_cpu_model i_cpu (.mclk, .eepromWriteBusy, .ctrlWrEn, .ctrlWrData, .spmExec, .lpmExec, .zPtr, .dataLow,
    .dataHigh, .globalIntEn);
  fsps_seq #(.PROG_TICKS(4)) i_dut (.mclk, .rst, .sysRst, .ctrlWrEn, .ctrlWrData, .ctrlRdData, .spmExec, .lpmExec,
    .zPtr, .dataLow, .dataHigh, .globalIntEn, .eepromWriteBusy, .rcOscClk, .lockProg, .fuseLowProg, .fuseHighProg,
    .fuseExtProg, .flashWordIdx, .flashWordData, .flashOpStart, .flashOpKind, .flashPageAddr, .flashOpActive,
    .lockProgMask, .readRwwBlocked, .cpuHalt, .spmReadyIrq, .readOverValid, .readOverData);
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic waitOp();
    int n;
    n = 0;
    while ((flashOpActive || readRwwBlocked) && n < 2000) begin
      @(posedge mclk) #1;
      n++;
    end
    chk(16'(n > 90 && n < 140), 16'h1);
    repeat (2) @(posedge mclk) #1;
  endtask
  task automatic doOp(input logic [4:0] cmd, input fsps_op_t kind, input logic [7:0] p, input logic [7:0] d);
    logic        prog;
    logic [15:0] expSt;
    prog = (cmd != CMD_LOCK);
    expSt = {2'h3, prog, prog && p >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE, prog, 3'h0, prog ? p : 8'h0};
    i_cpu.ctrlWr({3'h4, cmd});
    i_cpu.spm({1'h0, p, 7'h0}, {8'hff, d});
    chk({flashOpStart, flashOpActive, readRwwBlocked, cpuHalt, ctrlRdData[6], spmReadyIrq, 2'h0,
         prog ? flashPageAddr : 8'h0}, expSt);
    chk(16'(flashOpKind), 16'(kind));
    waitOp();
    chk(16'({spmReadyIrq, ctrlRdData}), {7'h0, 2'h3, prog, 6'h0});
  endtask
  task automatic load(input logic [5:0] w, input logic [15:0] d);
    i_cpu.ctrlWr({3'h4, CMD_LOAD});
    i_cpu.spm({9'h0, w, 1'h0}, d);
  endtask
  task automatic word(input logic [5:0] w, input logic [15:0] exp);
    flashWordIdx = w;
    @(posedge mclk) #1;
    chk(flashWordData, exp);
  endtask
  task automatic reen();
    i_cpu.ctrlWr({3'h4, CMD_REEN});
    i_cpu.spm(16'h0, 16'h0);
    chk(16'(ctrlRdData[6]), 16'h0);
    word(6'h05, 16'hffff);
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    rdExp[0] = ~fuseLowProg;
    rdExp[1] = {2'h3, ~lockProg};
    rdExp[2] = {5'h1f, ~fuseExtProg};
    rdExp[3] = ~fuseHighProg;
    repeat (10) @(posedge mclk);
    #1;
    rst = 0;
    chk(16'(ctrlRdData), 16'h0);
    i_cpu.globalIntEn = 1'h1;
    i_cpu.spm(16'h000c, 16'h1234);
    load(6'h05, 16'ha55a);
    word(6'h06, 16'hffff);
    word(6'h05, 16'ha55a);
    for (int i = 0; i < 2; i++) begin
      pg = i ? 8'he1 : 8'h10;
      doOp(CMD_ERASE, OP_ERASE, pg, 8'h00);
      reen();
      load(6'h05, 16'h0f0f);
      doOp(CMD_WRITE, OP_WRITE, pg, 8'h00);
      word(6'h05, 16'hffff);
      reen();
    end
    doOp(CMD_LOCK, OP_LOCK, 8'h00, 8'hc5);
    chk(16'(lockProgMask), 16'h003a);
    for (int i = 0; i < 4; i++) begin
      i_cpu.ctrlWr({3'h4, CMD_LOCK});
      @(posedge mclk) #1;
      i_cpu.lpm(16'(i));
      chk({readOverValid, 7'h0, readOverData}, {1'h1, 7'h0, rdExp[i]});
      chk(16'(ctrlRdData), 16'h0080);
    end
    i_cpu.globalIntEn = 1'h0;
    @(posedge mclk) #1;
    chk(16'(spmReadyIrq), 16'h0);
    i_cpu.globalIntEn = 1'h1;
    @(posedge mclk) #1;
    chk(16'(spmReadyIrq), 16'h1);
    i_cpu.ctrlWr({3'h4, CMD_LOCK});
    repeat (5) @(posedge mclk) #1;
    chk(16'(ctrlRdData), 16'h0080);
    i_cpu.lpm(16'h1);
    chk(16'(readOverValid), 16'h0);
    i_cpu.ctrlWr({3'h4, CMD_ERASE});
    repeat (4) @(posedge mclk) #1;
    i_cpu.spm(16'h0800, 16'h0);
    chk({flashOpActive, readRwwBlocked, 6'h0, ctrlRdData}, 16'h0080);
    load(6'h03, 16'hbeef);
    eepromWriteBusy = 1'h1;
    i_cpu.ctrlWr({3'h4, CMD_ERASE}, 1'b0);
    i_cpu.spm(16'h0800, 16'h0);
    chk({flashOpActive, readRwwBlocked, 6'h0, ctrlRdData}, 16'h0080);
    i_cpu.ctrlWr({3'h4, CMD_LOCK}, 1'b0);
    i_cpu.lpm(16'h1);
    chk(16'(readOverValid), 16'h0);
    word(6'h03, 16'hffff);
    eepromWriteBusy = 1'h0;
    load(6'h02, 16'h5a5a);
    i_cpu.ctrlWr(8'(CMD_ERASE));
    i_cpu.spm(16'h0800, 16'h0);
    sysRst = 1'h1;
    @(posedge mclk) #1;
    sysRst = 1'h0;
    flashWordIdx = 6'h02;
    @(posedge mclk) #1;
    chk({flashOpActive, flashWordData[14:0]}, 16'hffff);
    waitOp();
    print_verdict();
  end
endmodule
`default_nettype wire
